/* rtl/dfc_pkg.sv */
// package: offsets, fixed field values and reset values of the capability registers
// assumes: imported by every module of the dma function capability block
package dfc_pkg;
	// register byte offsets
	localparam logic [7:0]  OFS_PM_CAP      = 8'h40;
	localparam logic [7:0]  OFS_PM_CSR      = 8'h44;
	localparam logic [7:0]  OFS_MSI_CAP     = 8'h48;
	localparam logic [7:0]  OFS_MSI_ADDR_LO = 8'h4C;
	localparam logic [7:0]  OFS_MSI_ADDR_HI = 8'h50;
	localparam logic [7:0]  OFS_MSI_DATA    = 8'h54;
	localparam logic [7:0]  OFS_EXP_CAP     = 8'h68;
	localparam logic [7:0]  OFS_FUNC_CAP    = 8'h6C;
	localparam logic [7:0]  OFS_FUNC_CTL    = 8'h70;
	// read-only words and fixed bits
	localparam logic [31:0] PM_CAP_WORD     = 32'hC803_4801;
	localparam logic [31:0] MSI_CAP_FIXED   = 32'h0080_6805;
	localparam logic [31:0] EXP_CAP_WORD    = 32'h0002_A410;
	localparam logic [31:0] FUNC_CAP_WORD   = 32'h0000_8FC1;
	localparam logic        NO_SOFT_RESET   = 1'b1;
	// field positions
	localparam int          PS_LSB          = 0;
	localparam int          NSR_BIT         = 3;
	localparam int          PME_EN_BIT      = 8;
	localparam int          MSI_EN_BIT      = 16;
	localparam int          MME_LSB         = 20;
	localparam int          ERR_EN_LSB      = 0;
	localparam int          MPS_LSB         = 5;
	localparam int          ERR_STS_LSB     = 16;
	// power state encodings and reset values
	localparam logic [1:0]  PS_D0           = 2'h0;
	localparam logic [1:0]  PS_D3HOT        = 2'h3;
	localparam logic [1:0]  PS_RESET        = 2'h0;
	localparam logic [2:0]  MME_RESET       = 3'h0;
	localparam logic [2:0]  MPS_SUPPORTED   = 3'h1;
	localparam logic [2:0]  MPS_RESET       = 3'h0;
	localparam logic [3:0]  ERR_EN_RESET    = 4'h0;
	localparam logic [3:0]  ERR_STS_RESET   = 4'h0;
	localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
	localparam logic [15:0] DATA_RESET      = 16'h0000;
endpackage : dfc_pkg

/* rtl/dfc_msi_if.sv */
// interface: message interrupt settings and requests between register bank and generator
// assumes: both ends on the same core clock
`timescale 1ns/1ps
interface dfc_msi_if;
	logic        msiEnable;
	logic [63:0] msiAddr;
	logic [15:0] msiData;
	logic        irqEvent;
	logic        irqClear;
	logic        wrValid;
	logic [63:0] wrAddr;
	logic [31:0] wrData;
	logic        intxAssert;
	modport regs (output msiEnable, output msiAddr, output msiData, output irqEvent, output irqClear,
		input wrValid, input wrAddr, input wrData, input intxAssert);
	modport gen (input msiEnable, input msiAddr, input msiData, input irqEvent, input irqClear,
		output wrValid, output wrAddr, output wrData, output intxAssert);
endinterface : dfc_msi_if

/* rtl/dfc_msi_gen.sv */
// module: turns an interrupt event into a message write or a legacy level
// assumes: settings come from the register bank on the same clock
`timescale 1ns/1ps
module dfc_msi_gen
	import dfc_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	dfc_msi_if.gen    msi
);
	logic        wrValid_q;
	logic [63:0] wrAddr_q;
	logic [31:0] wrData_q;
	logic        intx_q;

	// message write when enabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrValid_q <= 1'b0;
			wrAddr_q  <= 64'h0000_0000_0000_0000;
			wrData_q  <= 32'h0000_0000;
		end else begin
			wrValid_q <= msi.irqEvent && msi.msiEnable; // [R09]
			if (msi.irqEvent && msi.msiEnable) begin
				wrAddr_q <= {msi.msiAddr[63:2], 2'b00}; // [R12]
				wrData_q <= {16'h0000, msi.msiData}; // [R13]
			end
		end
	end

	// legacy level only while messages are off, set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intx_q <= 1'b0;
		end else if (msi.msiEnable) begin
			intx_q <= 1'b0; // [R09]
		end else if (msi.irqEvent) begin
			intx_q <= 1'b1;
		end else if (msi.irqClear) begin
			intx_q <= 1'b0;
		end
	end

	assign msi.wrValid    = wrValid_q;
	assign msi.wrAddr     = wrAddr_q;
	assign msi.wrData     = wrData_q;
	assign msi.intxAssert = intx_q;

	a_msi_no_intx: assert property (@(posedge clk) disable iff (!arst_n) // [R09]
		msi.msiEnable |=> !intx_q)
		else $error("legacy interrupt active while message signalling enabled");
	a_msi_addr_align: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
		wrValid_q |-> (wrAddr_q[1:0] == 2'b00))
		else $error("message address not doubleword aligned");
endmodule : dfc_msi_gen

/* rtl/dfc_cap_regs.sv */
// module: capability registers of the dma function, reached by config reads and writes
// assumes: config requests, error and event inputs come from core logic on clk
// Behaviour
// [R01] two-bit read-write power state, D0 to D3hot, resets to D0
// [R02] writing D0 after D3 gives hot reset, downstream reset stays inactive
// [R03] no-internal-reset flag reads 1; D3hot to D0 then skips internal reset
// [R04] power event enable bit, default 0, gates the power event message
// [R05] power event status bit always reads 0
// [R06] power event support field reads constant 19h
// [R07] D1, D2 support and device-specific-init bits read 0
// [R08] message interrupt capability id 05h, next pointer 68h
// [R09] message enable: set allows messages and forbids legacy interrupt
// [R10] multiple message capable reads 000b; enable field read-write, reset 000b
// [R11] 64-bit address capable bit reads 1
// [R12] message address bits 31:2 read-write, bits 1:0 zero, used for writes
// [R13] 32-bit upper address and 16-bit data read-write, data upper half zero
// [R14] express capability id 10h, next A4h, version 2h, type 0h
// [R15] interrupt message number field reads zero
// [R16] max payload supported reads 001b, 256 bytes
// [R17] max payload field read-write, default 000b, clamped to supported maximum
// [R18] four error reporting enables in bits 0 to 3, default 0
// [R19] error detected flags set on detection regardless of enables, write 1 clears
// [R20] relaxed ordering enable and max read request size read 0
// [R21] both endpoint acceptable latency fields read 111b
// [R22] role-based error reporting bit reads 1, slot power fields read zero
// [R23] reserved and unsupported bits read zero and ignore writes
`timescale 1ns/1ps
module dfc_cap_regs
	import dfc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        cfgValid,
	input  wire logic        cfgWrite,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [3:0]  cfgByteEn,
	input  wire logic [31:0] cfgWdata,
	output logic             cfgReady,
	output logic [31:0]      cfgRdata,
	input  wire logic        pmeEventIn,
	input  wire logic [3:0]  errDetect,
	input  wire logic        irqEvent,
	input  wire logic        irqClear,
	output logic             powerEventMessage,
	output logic             hotReset,
	output logic             functionReset,
	output logic             downstreamResetOutN,
	output logic [3:0]       errMessage,
	output logic [1:0]       powerState,
	output logic [2:0]       maxPayload,
	output logic             msiWrValid,
	output logic [63:0]      msiWrAddr,
	output logic [31:0]      msiWrData,
	output logic             intxAssert
);
	// merge write data into an old word under byte enables
	function automatic logic [31:0] byteMerge(
		input logic [31:0] oldWord,
		input logic [31:0] newWord,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = oldWord;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = newWord[i*8 +: 8];
			end
		end
		return res;
	endfunction : byteMerge

	// clamp a requested payload encoding to the supported maximum
	function automatic logic [2:0] clampPayload(input logic [2:0] req);
		return (req > MPS_SUPPORTED) ? MPS_SUPPORTED : req;
	endfunction : clampPayload

	logic [1:0]  powerState_q;
	logic        pmeEnable_q;
	logic        msiEnable_q;
	logic [2:0]  mme_q;
	logic [29:0] msiAddrLo_q;
	logic [31:0] msiAddrHi_q;
	logic [15:0] msiData_q;
	logic [3:0]  errEnable_q;
	logic [2:0]  maxPayload_q;
	logic [3:0]  errStatus_q;
	logic        cfgReady_q;
	logic [31:0] cfgRdata_q;
	logic        pmeMsg_q;
	logic        hotReset_q;
	logic        funcReset_q;
	logic        dsResetN_q;
	logic [3:0]  errMsg_q;

	logic        wrEn;
	logic        rdEn;
	logic [31:0] pmCsrWord;
	logic [31:0] msiCapWord;
	logic [31:0] funcCtlWord;
	logic [31:0] readWord;
	logic [31:0] pmCsrNew;
	logic [31:0] msiCapNew;
	logic [31:0] funcCtlNew;
	logic        psToD0;
	logic [31:0] addrLoNew;
	logic [31:0] dataNew;

	dfc_msi_if msiBus ();

	assign wrEn = cfgValid && cfgWrite;
	assign rdEn = cfgValid && !cfgWrite;

	// current views of the writable words, reserved bits zero
	always_comb begin
		pmCsrWord = 32'h0000_0000; // [R05]
		pmCsrWord[PS_LSB +: 2] = powerState_q; // [R01]
		pmCsrWord[NSR_BIT] = NO_SOFT_RESET; // [R03]
		pmCsrWord[PME_EN_BIT] = pmeEnable_q; // [R04]
		msiCapWord = MSI_CAP_FIXED; // [R08] [R11]
		msiCapWord[MSI_EN_BIT] = msiEnable_q;
		msiCapWord[MME_LSB +: 3] = mme_q; // [R10]
		funcCtlWord = 32'h0000_0000; // [R20]
		funcCtlWord[ERR_EN_LSB +: 4] = errEnable_q;
		funcCtlWord[MPS_LSB +: 3] = maxPayload_q;
		funcCtlWord[ERR_STS_LSB +: 4] = errStatus_q;
	end

	assign pmCsrNew   = byteMerge(pmCsrWord, cfgWdata, cfgByteEn);
	assign msiCapNew  = byteMerge(msiCapWord, cfgWdata, cfgByteEn);
	assign funcCtlNew = byteMerge(funcCtlWord, cfgWdata, cfgByteEn);
	assign addrLoNew  = byteMerge({msiAddrLo_q, 2'b00}, cfgWdata, cfgByteEn);
	assign dataNew    = byteMerge({16'h0000, msiData_q}, cfgWdata, cfgByteEn);
	assign psToD0     = wrEn && (cfgAddr == OFS_PM_CSR) && cfgByteEn[0]
		&& (cfgWdata[PS_LSB +: 2] == PS_D0) && (powerState_q == PS_D3HOT);

	// read data selection, unmapped offsets read zero
	always_comb begin
		unique case (cfgAddr)
			OFS_PM_CAP:      readWord = PM_CAP_WORD; // [R06] [R07]
			OFS_PM_CSR:      readWord = pmCsrWord;
			OFS_MSI_CAP:     readWord = msiCapWord;
			OFS_MSI_ADDR_LO: readWord = {msiAddrLo_q, 2'b00}; // [R12]
			OFS_MSI_ADDR_HI: readWord = msiAddrHi_q;
			OFS_MSI_DATA:    readWord = {16'h0000, msiData_q}; // [R13]
			OFS_EXP_CAP:     readWord = EXP_CAP_WORD; // [R14] [R15]
			OFS_FUNC_CAP:    readWord = FUNC_CAP_WORD; // [R16] [R21] [R22]
			OFS_FUNC_CTL:    readWord = funcCtlWord;
			default:         readWord = 32'h0000_0000; // [R23]
		endcase
	end

	// config answer one cycle after the request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgReady_q <= 1'b0;
			cfgRdata_q <= 32'h0000_0000;
		end else begin
			cfgReady_q <= cfgValid;
			if (rdEn) begin
				cfgRdata_q <= readWord;
			end
		end
	end

	// power management control
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			powerState_q <= PS_RESET;
			pmeEnable_q  <= 1'b0;
		end else if (wrEn && (cfgAddr == OFS_PM_CSR)) begin
			powerState_q <= pmCsrNew[PS_LSB +: 2]; // [R01]
			pmeEnable_q  <= pmCsrNew[PME_EN_BIT]; // [R04]
		end
	end

	// hot reset on D3 to D0, downstream reset never driven by it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hotReset_q  <= 1'b0;
			funcReset_q <= 1'b0;
			dsResetN_q  <= 1'b1;
		end else begin
			hotReset_q  <= psToD0; // [R02]
			funcReset_q <= psToD0 && !NO_SOFT_RESET; // [R03]
			dsResetN_q  <= 1'b1; // [R02]
		end
	end

	// power event message forwarding
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pmeMsg_q <= 1'b0;
		end else begin
			pmeMsg_q <= pmeEventIn && pmeEnable_q; // [R04]
		end
	end

	// message interrupt capability and address registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			msiEnable_q <= 1'b0;
			mme_q       <= MME_RESET;
		end else if (wrEn && (cfgAddr == OFS_MSI_CAP)) begin
			msiEnable_q <= msiCapNew[MSI_EN_BIT]; // [R09]
			mme_q       <= msiCapNew[MME_LSB +: 3]; // [R10]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			msiAddrLo_q <= ADDR_RESET[31:2];
		end else if (wrEn && (cfgAddr == OFS_MSI_ADDR_LO)) begin
			msiAddrLo_q <= addrLoNew[31:2]; // [R12]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			msiAddrHi_q <= ADDR_RESET;
		end else if (wrEn && (cfgAddr == OFS_MSI_ADDR_HI)) begin
			msiAddrHi_q <= byteMerge(msiAddrHi_q, cfgWdata, cfgByteEn); // [R13]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			msiData_q <= DATA_RESET;
		end else if (wrEn && (cfgAddr == OFS_MSI_DATA)) begin
			msiData_q <= dataNew[15:0]; // [R13]
		end
	end

	// function control: error enables and payload size
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			errEnable_q  <= ERR_EN_RESET;
			maxPayload_q <= MPS_RESET;
		end else if (wrEn && (cfgAddr == OFS_FUNC_CTL)) begin
			errEnable_q  <= funcCtlNew[ERR_EN_LSB +: 4]; // [R18]
			maxPayload_q <= clampPayload(funcCtlNew[MPS_LSB +: 3]); // [R17]
		end
	end

	// error flags: detection wins over a write-one clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			errStatus_q <= ERR_STS_RESET;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (errDetect[i]) begin
					errStatus_q[i] <= 1'b1; // [R19]
				end else if (wrEn && (cfgAddr == OFS_FUNC_CTL) && cfgByteEn[2]
					&& cfgWdata[ERR_STS_LSB + i]) begin
					errStatus_q[i] <= 1'b0; // [R19]
				end
			end
		end
	end

	// error messages only for enabled classes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			errMsg_q <= 4'h0;
		end else begin
			errMsg_q <= errDetect & errEnable_q; // [R18]
		end
	end

	// message interrupt generator hookup
	assign msiBus.msiEnable = msiEnable_q;
	assign msiBus.msiAddr   = {msiAddrHi_q, msiAddrLo_q, 2'b00};
	assign msiBus.msiData   = msiData_q;
	assign msiBus.irqEvent  = irqEvent;
	assign msiBus.irqClear  = irqClear;

	dfc_msi_gen u_msiGen (
		.clk    (clk),
		.arst_n (arst_n),
		.msi    (msiBus)
	);

	assign cfgReady            = cfgReady_q;
	assign cfgRdata            = cfgRdata_q;
	assign powerEventMessage   = pmeMsg_q;
	assign hotReset            = hotReset_q;
	assign functionReset       = funcReset_q;
	assign downstreamResetOutN = dsResetN_q;
	assign errMessage          = errMsg_q;
	assign powerState          = powerState_q;
	assign maxPayload          = maxPayload_q;
	assign msiWrValid          = msiBus.wrValid;
	assign msiWrAddr           = msiBus.wrAddr;
	assign msiWrData           = msiBus.wrData;
	assign intxAssert          = msiBus.intxAssert;

	a_ps_write_store: assert property (@(posedge clk) disable iff (!arst_n) // [R01]
		(wrEn && (cfgAddr == OFS_PM_CSR) && cfgByteEn[0])
		|=> (powerState_q == $past(cfgWdata[1:0])))
		else $error("power state did not take written value");
	a_hot_reset_pulse: assert property (@(posedge clk) disable iff (!arst_n) // [R02]
		psToD0 |=> (hotReset_q && dsResetN_q) ##1 !hotReset_q)
		else $error("hot reset not a single pulse with downstream reset idle");
	a_no_soft_reset: assert property (@(posedge clk) disable iff (!arst_n) // [R03]
		!funcReset_q && dsResetN_q)
		else $error("internal or downstream reset driven");
	a_pme_forward: assert property (@(posedge clk) disable iff (!arst_n) // [R04]
		(pmeEventIn && pmeEnable_q) |=> pmeMsg_q)
		else $error("power event message not forwarded");
	a_pme_gated: assert property (@(posedge clk) disable iff (!arst_n) // [R04]
		!pmeEnable_q |=> !pmeMsg_q)
		else $error("power event message while disabled");
	a_pm_cap_read: assert property (@(posedge clk) disable iff (!arst_n) // [R06]
		(rdEn && (cfgAddr == OFS_PM_CAP)) |=> (cfgReady_q && (cfgRdata_q == 32'hC803_4801)))
		else $error("power capability word wrong");
	a_pm_status_zero: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
		(rdEn && (cfgAddr == OFS_PM_CSR)) |=> (cfgRdata_q[15] == 1'b0) && cfgRdata_q[3])
		else $error("power event status or no-reset flag wrong");
	a_mps_clamp: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
		(wrEn && (cfgAddr == OFS_FUNC_CTL) && cfgByteEn[0] && (cfgWdata[7:5] > 3'h1))
		|=> (maxPayload_q == 3'h1))
		else $error("payload size not clamped");
	a_err_sticky: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
		errDetect[2] |=> errStatus_q[2])
		else $error("fatal error flag lost");
	a_err_unmapped: assert property (@(posedge clk) disable iff (!arst_n) // [R23]
		(rdEn && (cfgAddr == 8'h58)) |=> (cfgRdata_q == 32'h0000_0000))
		else $error("unmapped offset read nonzero");
endmodule : dfc_cap_regs

/* tb/dfc_cfg_host.sv */
// partner: config request master in the place of the root complex
// assumes: shares clk with the register bank, one request in flight at a time
`timescale 1ns/1ps
module dfc_cfg_host (
	input  wire logic        clk,
	output logic             cfgValid,
	output logic             cfgWrite,
	output logic [7:0]       cfgAddr,
	output logic [3:0]       cfgByteEn,
	output logic [31:0]      cfgWdata,
	input  wire logic        cfgReady,
	input  wire logic [31:0] cfgRdata
);
	initial begin
		cfgValid  = 1'b0;
		cfgWrite  = 1'b0;
		cfgAddr   = 8'h00;
		cfgByteEn = 4'h0;
		cfgWdata  = 32'h0000_0000;
	end

	// one-cycle strobe, released lines inverted, ready awaited for 8 edges
	task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] rd, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		rd = 32'h0000_0000;
		@(posedge clk);
		cfgValid  <= 1'b1;
		cfgWrite  <= wr;
		cfgAddr   <= a;
		cfgByteEn <= be;
		cfgWdata  <= d;
		@(posedge clk);
		cfgValid  <= 1'b0;
		cfgWrite  <= ~wr;
		cfgAddr   <= ~a;
		cfgByteEn <= ~be;
		cfgWdata  <= ~d;
		while (!ok && n < 8) begin
			@(posedge clk);
			n++;
			if (cfgReady === 1'b1) begin
				ok = 1'b1;
				rd = cfgRdata;
			end
		end
	endtask : access
endmodule : dfc_cfg_host

/* tb/dfc_cap_regs_tb_top.sv */
// testbench: capability register bank against a behavioural register model
// assumes: dfc_cfg_host drives the config port, events driven here
`timescale 1ns/1ps
module dfc_cap_regs_tb_top
	import dfc_pkg::*;
();
	localparam int LIMIT = 20000;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        pmeEventIn = 1'b0;
	logic [3:0]  errDetect = 4'h0;
	logic        irqEvent = 1'b0;
	logic        irqClear = 1'b0;
	logic        cfgValid, cfgWrite, cfgReady, powerEventMessage, hotReset, functionReset;
	logic        downstreamResetOutN, msiWrValid, intxAssert;
	logic [7:0]  cfgAddr;
	logic [3:0]  cfgByteEn, errMessage;
	logic [31:0] cfgWdata, cfgRdata, msiWrData;
	logic [1:0]  powerState, mPs;
	logic [2:0]  maxPayload, mMme, mMps;
	logic [63:0] msiWrAddr;
	logic        mPme, mMsi, mIntx;
	logic [31:0] mLo, mHi;
	logic [15:0] mData;
	logic [3:0]  mEn, mSts;
	int          failCount = 0, nChecks = 0, cycles = 0, expHot = 0, seenHot = 0, badRst = 0;
	logic [7:0]  offs [13] = '{OFS_PM_CAP, OFS_PM_CSR, OFS_MSI_CAP, OFS_MSI_ADDR_LO, OFS_MSI_ADDR_HI,
		OFS_MSI_DATA, OFS_EXP_CAP, OFS_FUNC_CAP, OFS_FUNC_CTL, 8'h00, 8'h58, 8'h74, 8'hFC};

	dfc_cfg_host host (.clk(clk), .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
		.cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgReady(cfgReady), .cfgRdata(cfgRdata));
	dfc_cap_regs uut (.clk(clk), .arst_n(arst_n), .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
		.cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgReady(cfgReady), .cfgRdata(cfgRdata),
		.pmeEventIn(pmeEventIn), .errDetect(errDetect), .irqEvent(irqEvent), .irqClear(irqClear),
		.powerEventMessage(powerEventMessage), .hotReset(hotReset), .functionReset(functionReset),
		.downstreamResetOutN(downstreamResetOutN), .errMessage(errMessage), .powerState(powerState),
		.maxPayload(maxPayload), .msiWrValid(msiWrValid), .msiWrAddr(msiWrAddr), .msiWrData(msiWrData),
		.intxAssert(intxAssert));

	always #2 clk = ~clk;

	// pulse counting, reset output watch, run limit
	always @(negedge clk) begin
		cycles++;
		if (hotReset === 1'b1) begin
			seenHot++;
		end
		if (arst_n && (downstreamResetOutN !== 1'b1 || functionReset !== 1'b0)) begin
			badRst++;
		end
		if (cycles == LIMIT) begin
			failCount++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : check_word

	task automatic check_port(input string what, input logic [63:0] e, input logic [63:0] g);
		nChecks++;
		if (g !== e) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : check_port

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) merge[8*i +: 8] = n[8*i +: 8];
		end
	endfunction : merge

	function automatic logic [31:0] exp_word(input logic [7:0] a);
		case (a)
			OFS_PM_CAP:      exp_word = 32'hC803_4801;
			OFS_PM_CSR:      exp_word = {23'h0, mPme, 4'h0, 1'b1, 1'b0, mPs};
			OFS_MSI_CAP:     exp_word = {8'h00, 1'b1, mMme, 3'h0, mMsi, 8'h68, 8'h05};
			OFS_MSI_ADDR_LO: exp_word = {mLo[31:2], 2'b00};
			OFS_MSI_ADDR_HI: exp_word = mHi;
			OFS_MSI_DATA:    exp_word = {16'h0000, mData};
			OFS_EXP_CAP:     exp_word = {8'h00, 4'h0, 4'h2, 8'hA4, 8'h10};
			OFS_FUNC_CAP:    exp_word = {16'h0000, 1'b1, 3'h0, 3'h7, 3'h7, 3'h0, 3'h1};
			OFS_FUNC_CTL:    exp_word = {12'h000, mSts, 8'h00, mMps, 1'b0, mEn};
			default:         exp_word = 32'h0000_0000;
		endcase
	endfunction : exp_word

	task automatic m_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] t;
		t = merge({16'h0000, mData}, d, be);
		case (a)
			OFS_PM_CSR: begin
				if (be[0] && mPs == PS_D3HOT && d[1:0] == PS_D0) expHot++;
				if (be[0]) mPs = d[1:0];
				if (be[1]) mPme = d[8];
			end
			OFS_MSI_CAP: begin
				if (be[2]) mMsi = d[16];
				if (be[2]) mMme = d[22:20];
			end
			OFS_MSI_ADDR_LO: mLo = merge(mLo, d, be);
			OFS_MSI_ADDR_HI: mHi = merge(mHi, d, be);
			OFS_MSI_DATA:    mData = t[15:0];
			OFS_FUNC_CTL: begin
				if (be[0]) mEn = d[3:0];
				if (be[0]) mMps = (d[7:5] > MPS_SUPPORTED) ? MPS_SUPPORTED : d[7:5];
				if (be[2]) mSts = mSts & ~d[19:16];
			end
			default: ;
		endcase
		if (mMsi) mIntx = 1'b0;
	endtask : m_write

	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] rd;
		logic        ok;
		host.access(1'b1, a, be, d, rd, ok);
		check_port("cfgReady", 1'b1, ok);
		m_write(a, be, d);
	endtask : cfg_write

	task automatic read_check(input logic [7:0] a);
		logic [31:0] rd;
		logic        ok;
		host.access(1'b0, a, 4'hF, $urandom, rd, ok);
		check_port("cfgReady", 1'b1, ok);
		check_word($sformatf("read %h", a), exp_word(a), rd);
	endtask : read_check

	task automatic read_all();
		foreach (offs[i]) read_check(offs[i]);
	endtask : read_all

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		{mPs, mPme, mMsi, mMme, mMps, mLo, mHi, mData, mEn, mSts, mIntx} = '0;
	endtask : do_reset

	// one event pulse, registered answer one cycle on, gone the cycle after
	task automatic pulse_events(input logic pme, input logic [3:0] err, input logic irq, input logic clr);
		@(posedge clk);
		pmeEventIn <= pme;
		errDetect  <= err;
		irqEvent   <= irq;
		irqClear   <= clr;
		@(posedge clk);
		pmeEventIn <= 1'b0;
		errDetect  <= 4'h0;
		irqEvent   <= 1'b0;
		irqClear   <= 1'b0;
		mSts = mSts | err;
		if (irq && !mMsi) mIntx = 1'b1;
		else if (clr) mIntx = 1'b0;
		#1;
		check_port("powerEventMessage", pme & mPme, powerEventMessage);
		check_port("errMessage", err & mEn, errMessage);
		check_port("msiWrValid", irq & mMsi, msiWrValid);
		if (irq && mMsi) check_port("msiWrAddr", {mHi, mLo[31:2], 2'b00}, msiWrAddr);
		if (irq && mMsi) check_port("msiWrData", {16'h0000, mData}, msiWrData);
		check_port("intxAssert", mIntx, intxAssert);
		@(posedge clk);
		#1;
		check_port("event pulses end", 0, {powerEventMessage, errMessage, msiWrValid});
	endtask : pulse_events

	initial begin
		logic [7:0] a;
		void'($urandom(32'h3a87));
		do_reset();
		read_all();
		$display("test reset values done");
		for (int k = 0; k < 48; k++) begin
			a = offs[$urandom_range(12, 0)];
			cfg_write(a, 4'($urandom), $urandom);
			read_check(a);
			check_port("powerState", mPs, powerState);
			check_port("maxPayload", mMps, maxPayload);
		end
		$display("test random access done");
		for (int k = 0; k < 8; k++) begin
			cfg_write(OFS_FUNC_CTL, 4'h1, (32'(k) << 5) | ($urandom & 32'hF));
			read_check(OFS_FUNC_CTL);
			check_port("maxPayload", mMps, maxPayload);
		end
		$display("test payload clamp done");
		for (int k = 0; k < 4; k++) begin
			cfg_write(OFS_PM_CSR, 4'h1, 32'(k));
			cfg_write(OFS_PM_CSR, 4'h1, 32'h0000_0000);
			check_port("hotReset count", expHot, seenHot);
			read_check(OFS_PM_CSR);
		end
		$display("test power state done");
		for (int k = 0; k < 2; k++) begin
			cfg_write(OFS_PM_CSR, 4'h2, 32'(k) << 8);
			pulse_events(1'b1, 4'h0, 1'b0, 1'b0);
		end
		$display("test power event done");
		for (int k = 0; k < 8; k++) begin
			cfg_write(OFS_FUNC_CTL, 4'h1, $urandom);
			pulse_events(1'b0, 4'h1 << (k % 4), 1'b0, 1'b0);
			read_check(OFS_FUNC_CTL);
			cfg_write(OFS_FUNC_CTL, 4'h4, $urandom);
			read_check(OFS_FUNC_CTL);
		end
		$display("test error flags done");
		cfg_write(OFS_MSI_ADDR_LO, 4'hF, $urandom);
		cfg_write(OFS_MSI_ADDR_HI, 4'hF, $urandom);
		cfg_write(OFS_MSI_DATA, 4'hF, $urandom);
		for (int k = 0; k < 2; k++) begin
			cfg_write(OFS_MSI_CAP, 4'h4, ($urandom & 32'h0070_0000) | (32'(k) << 16));
			pulse_events(1'b0, 4'h0, 1'b1, 1'b0);
			if (k == 0) pulse_events(1'b0, 4'h0, 1'b0, 1'b1);
			if (k == 0) pulse_events(1'b0, 4'h0, 1'b1, 1'b0);
		end
		$display("test message interrupt done");
		do_reset();
		read_all();
		check_port("hotReset count", expHot, seenHot);
		check_port("reset outputs", 0, badRst);
		$display("test second reset done");
		results();
	end
endmodule : dfc_cap_regs_tb_top
